// ==== src/ptpsta_pkg.sv ====
//------------------------------------------------------------
// Shared constants and carriers of the system time access block
//------------------------------------------------------------
package ptpsta_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [11:0] OFF_CTRL = 12'h700;
  localparam logic [11:0] OFF_INCR = 12'h704;
  localparam logic [11:0] OFF_SEC = 12'h708;
  localparam logic [11:0] OFF_SUB = 12'h70c;
  localparam logic [11:0] OFF_ADJ_SEC = 12'h710;
  localparam logic [11:0] OFF_ADJ_SUB = 12'h714;

  // Field positions.
  localparam int CTRL_LOAD_BIT = 2;
  localparam int CTRL_STEP_BIT = 3;
  localparam int CTRL_DEC_BIT = 9;
  localparam int ADJ_DIR_BIT = 31;

  // Reset values.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_INCR = 8'h00;

  // Sub-second rollover limits.
  localparam logic [30:0] DEC_MAX = 31'h3b9a_c9ff;
  localparam logic [30:0] BIN_MAX = 31'h07ff_ffff;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Time value: whole seconds and fraction of a second.
  typedef struct packed {
    logic [31:0] whole_seconds;
    logic [30:0] fraction_seconds;
  } ptpsta_time_type;

  // Adjustment value with its direction.
  typedef struct packed {
    logic adjust_direction;
    logic [31:0] whole_seconds;
    logic [30:0] fraction_seconds;
  } ptpsta_adjust_type;

endpackage : ptpsta_pkg

// ==== src/ptpsta_keeper.sv ====
//------------------------------------------------------------
// Running system time with load and step
//------------------------------------------------------------
module ptpsta_keeper (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Control.
  input wire logic [7:0] incr,
  input wire logic decimal_rollover_select,
  input wire logic time_load_request,
  input wire logic time_step_request,
  input wire ptpsta_pkg::ptpsta_adjust_type adjust,
  // Results.
  output logic [31:0] now_seconds,
  output logic [30:0] now_fraction,
  output logic load_done,
  output logic step_done
);

  typedef struct packed {
    ptpsta_pkg::ptpsta_time_type now;
    logic load_done;
    logic step_done;
  } ptpsta_keep_type;

  ptpsta_keep_type s_q;
  ptpsta_keep_type s_d;

  // Adds to the fraction and wraps at the selected rollover value.
  // rollover wrap
  function automatic logic [31:0] wrap_add(input logic [30:0] frac, input logic [30:0] add,
                                           input logic dec);
    logic [31:0] lim;
    logic [31:0] sum;
    lim = dec ? {1'b0, ptpsta_pkg::DEC_MAX} : {1'b0, ptpsta_pkg::BIN_MAX};
    sum = {1'b0, frac} + {1'b0, add};
    if (sum > lim)
    begin
      sum = sum - lim - 32'h1;
      wrap_add = {1'b1, sum[30:0]};
    end
    else
    begin
      wrap_add = sum;
    end
  endfunction : wrap_add

  // Next time: load beats step, step beats the normal tick.
  always_comb
  begin
    logic [31:0] r;
    logic [31:0] lim;
    r = 32'h0;
    lim = decimal_rollover_select ? {1'b0, ptpsta_pkg::DEC_MAX} : {1'b0, ptpsta_pkg::BIN_MAX};
    s_d = s_q;
    s_d.load_done = 1'b0;
    s_d.step_done = 1'b0;
    if (time_load_request && !s_q.load_done)
    begin
      s_d.now.whole_seconds = adjust.whole_seconds;
      s_d.now.fraction_seconds = adjust.fraction_seconds;
      s_d.load_done = 1'b1;
    end
    else if (time_step_request && !s_q.step_done)
    begin
      if (!adjust.adjust_direction)
      begin
        r = wrap_add(s_q.now.fraction_seconds, adjust.fraction_seconds, decimal_rollover_select);
        s_d.now.fraction_seconds = r[30:0];
        s_d.now.whole_seconds = s_q.now.whole_seconds + adjust.whole_seconds + 32'(r[31]);
      end
      else if (s_q.now.fraction_seconds >= adjust.fraction_seconds)
      begin
        s_d.now.fraction_seconds = s_q.now.fraction_seconds - adjust.fraction_seconds;
        s_d.now.whole_seconds = s_q.now.whole_seconds - adjust.whole_seconds;
      end
      else
      begin
        r = {1'b0, s_q.now.fraction_seconds} + lim + 32'h1 - {1'b0, adjust.fraction_seconds};
        s_d.now.fraction_seconds = r[30:0];
        s_d.now.whole_seconds = s_q.now.whole_seconds - adjust.whole_seconds - 32'h1;
      end
      s_d.step_done = 1'b1;
    end
    else
    begin
      r = wrap_add(s_q.now.fraction_seconds, {23'h0, incr}, decimal_rollover_select);
      s_d.now.fraction_seconds = r[30:0];
      s_d.now.whole_seconds = s_q.now.whole_seconds + 32'(r[31]);
    end
  end

  // State register.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Results leave straight from the state register.
  assign now_seconds = s_q.now.whole_seconds;
  assign now_fraction = s_q.now.fraction_seconds;
  assign load_done = s_q.load_done;
  assign step_done = s_q.step_done;

endmodule : ptpsta_keeper

// ==== src/ptpsta_top.sv ====
// How it works
// - Seconds and sub-seconds of running time are readable and refresh continuously.
// - Readable time passes a sampling stage, so reads lag true time slightly.
// - Seconds readout is 32 bits, read-only, zero after reset.
// - Sub-seconds readout uses bits 30:0; bit 31 reads zero.
// - Decimal mode: fraction wraps after 0x3B9A_C9FF and seconds advance.
// - Load replaces seconds with adjustment seconds; step applies them as offset.
// - Adjustment bit 31 set subtracts, clear adds.
// - Binary mode: fraction wraps after 0x7FF_FFFF.
// - Load request overwrites time, then its bit clears itself.
// - Step request adds or subtracts, then its bit clears itself.
//
// Added by the designer: register access over AXI4-Lite.
module ptpsta_top (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Write address channel.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel.
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRESP = 2'b01,
    BUS_RDATA = 2'b11
  } ptpsta_bus_type;

  typedef struct packed {
    ptpsta_bus_type bus;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic time_load_bit;
    logic time_step_bit;
    logic decimal_rollover_select;
    logic [7:0] incr;
    ptpsta_pkg::ptpsta_adjust_type adj;
    ptpsta_pkg::ptpsta_time_type snap;
  } ptpsta_state_type;

  ptpsta_state_type s_q;
  ptpsta_state_type s_d;
  logic [31:0] tk_sec;
  logic [30:0] tk_frac;
  logic tk_load_done;
  logic tk_step_done;
  logic rd_fire;
  logic wr_commit;

  //------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------

  // Merges write data into an old word under the byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction : merge

  //------------------------------------------------------------
  // Time keeper
  //------------------------------------------------------------

  ptpsta_keeper u_keeper (
    .core_clk(core_clk),
    .rst(rst),
    .incr(s_q.incr),
    .decimal_rollover_select(s_q.decimal_rollover_select),
    .time_load_request(s_q.time_load_bit),
    .time_step_request(s_q.time_step_bit),
    .adjust(s_q.adj),
    .now_seconds(tk_sec),
    .now_fraction(tk_frac),
    .load_done(tk_load_done),
    .step_done(tk_step_done)
  );

  //------------------------------------------------------------
  // Register bus slave and control state
  //------------------------------------------------------------

  // A read handshake wins; a complete write waits for the idle state.
  assign rd_fire = (s_q.bus == BUS_IDLE) && s_axi_arvalid && s_q.arready;
  assign wr_commit = (s_q.bus == BUS_IDLE) && s_q.aw_got && s_q.w_got && !rd_fire;

  // Next state of bus channels, registers and time sample.
  always_comb
  begin
    logic [31:0] w;
    w = 32'h0;
    s_d = s_q;
    s_d.snap.whole_seconds = tk_sec;
    s_d.snap.fraction_seconds = tk_frac;
    if (tk_load_done)
    begin
      s_d.time_load_bit = 1'b0;
    end
    if (tk_step_done)
    begin
      s_d.time_step_bit = 1'b0;
    end
    if (s_axi_awvalid && s_q.awready)
    begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    case (s_q.bus)
      BUS_IDLE:
      begin
        s_d.awready = !s_d.aw_got;
        s_d.wready = !s_d.w_got;
        s_d.arready = 1'b1;
        if (rd_fire)
        begin
          s_d.rresp = ptpsta_pkg::RESP_OKAY;
          case (s_axi_araddr)
            ptpsta_pkg::OFF_CTRL: s_d.rdata = (32'(s_q.time_load_bit) << ptpsta_pkg::CTRL_LOAD_BIT)
                                   | (32'(s_q.time_step_bit) << ptpsta_pkg::CTRL_STEP_BIT)
                                   | (32'(s_q.decimal_rollover_select) << ptpsta_pkg::CTRL_DEC_BIT);
            ptpsta_pkg::OFF_INCR: s_d.rdata = {24'h0, s_q.incr};
            ptpsta_pkg::OFF_SEC: s_d.rdata = s_q.snap.whole_seconds;
            ptpsta_pkg::OFF_SUB: s_d.rdata = {1'b0, s_q.snap.fraction_seconds};
            ptpsta_pkg::OFF_ADJ_SEC: s_d.rdata = s_q.adj.whole_seconds;
            ptpsta_pkg::OFF_ADJ_SUB: s_d.rdata = {s_q.adj.adjust_direction,
                                                  s_q.adj.fraction_seconds};
            default:
            begin
              s_d.rdata = ptpsta_pkg::RST_WORD;
              s_d.rresp = ptpsta_pkg::RESP_SLVERR;
            end
          endcase
          s_d.rvalid = 1'b1;
          s_d.awready = 1'b0;
          s_d.wready = 1'b0;
          s_d.arready = 1'b0;
          s_d.bus = BUS_RDATA;
        end
        else if (wr_commit)
        begin
          s_d.bresp = ptpsta_pkg::RESP_OKAY;
          case (s_q.awaddr)
            ptpsta_pkg::OFF_CTRL:
            begin
              w = merge(ptpsta_pkg::RST_WORD, s_q.wdata, s_q.wstrb);
              // A set lands after the hardware clear, so it is never lost.
              s_d.time_load_bit = s_d.time_load_bit | w[ptpsta_pkg::CTRL_LOAD_BIT];
              s_d.time_step_bit = s_d.time_step_bit | w[ptpsta_pkg::CTRL_STEP_BIT];
              if (s_q.wstrb[ptpsta_pkg::CTRL_DEC_BIT/8])
              begin
                s_d.decimal_rollover_select = w[ptpsta_pkg::CTRL_DEC_BIT];
              end
            end
            ptpsta_pkg::OFF_INCR:
            begin
              w = merge({24'h0, s_q.incr}, s_q.wdata, s_q.wstrb);
              s_d.incr = w[7:0];
            end
            ptpsta_pkg::OFF_SEC, ptpsta_pkg::OFF_SUB:
            begin
              s_d.bresp = ptpsta_pkg::RESP_OKAY;
            end
            ptpsta_pkg::OFF_ADJ_SEC:
            begin
              s_d.adj.whole_seconds = merge(s_q.adj.whole_seconds, s_q.wdata, s_q.wstrb);
            end
            ptpsta_pkg::OFF_ADJ_SUB:
            begin
              w = merge({s_q.adj.adjust_direction, s_q.adj.fraction_seconds}, s_q.wdata,
                        s_q.wstrb);
              s_d.adj.adjust_direction = w[ptpsta_pkg::ADJ_DIR_BIT];
              s_d.adj.fraction_seconds = w[30:0];
            end
            default:
            begin
              s_d.bresp = ptpsta_pkg::RESP_SLVERR;
            end
          endcase
          s_d.aw_got = 1'b0;
          s_d.w_got = 1'b0;
          s_d.bvalid = 1'b1;
          s_d.awready = 1'b0;
          s_d.wready = 1'b0;
          s_d.arready = 1'b0;
          s_d.bus = BUS_WRESP;
        end
      end
      BUS_WRESP:
      begin
        if (s_axi_bready)
        begin
          s_d.bvalid = 1'b0;
          s_d.bus = BUS_IDLE;
        end
      end
      BUS_RDATA:
      begin
        if (s_axi_rready)
        begin
          s_d.rvalid = 1'b0;
          s_d.bus = BUS_IDLE;
        end
      end
      default:
      begin
        s_d.bus = BUS_IDLE;
      end
    endcase
  end

  // State register; everything resets to zero.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Bus outputs come straight from the state register.
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_arready = s_q.arready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence load_start;
    s_q.time_load_bit && !tk_load_done;
  endsequence

  sequence load_finish;
    tk_load_done && tk_sec == $past(s_q.adj.whole_seconds) && !wr_commit;
  endsequence

  sequence step_start;
    s_q.time_step_bit && !s_q.time_load_bit && !tk_step_done;
  endsequence

  load_apply_a: assert property (load_start |=> load_finish ##1 !s_q.time_load_bit)
    else $error("load did not copy seconds and clear its request");
  load_clear_a: assert property (tk_load_done && !wr_commit |=> !s_q.time_load_bit)
    else $error("load request did not clear");
  step_clear_a: assert property (step_start ##1 (tk_step_done && !wr_commit)
                                 |=> !s_q.time_step_bit)
    else $error("step request did not clear");
  step_sub_a: assert property (step_start and (s_q.adj.adjust_direction
                               && tk_frac >= s_q.adj.fraction_seconds)
                               |=> tk_frac == $past(tk_frac) - $past(s_q.adj.fraction_seconds))
    else $error("subtracting step gave a wrong fraction");
  pair_sample_a: assert property (1'b1 |=> s_q.snap.whole_seconds == $past(tk_sec)
                                  && s_q.snap.fraction_seconds == $past(tk_frac))
    else $error("time sample is not one coherent pair");
  sec_read_a: assert property (rd_fire && s_axi_araddr == ptpsta_pkg::OFF_SEC
                               |=> s_axi_rvalid && s_axi_rdata == $past(s_q.snap.whole_seconds))
    else $error("seconds readout wrong");
  sub_read_a: assert property (rd_fire && s_axi_araddr == ptpsta_pkg::OFF_SUB
                               |=> s_axi_rdata == {1'b0, $past(s_q.snap.fraction_seconds)})
    else $error("fraction readout wrong");
  dec_wrap_a: assert property (s_q.decimal_rollover_select && !s_q.time_load_bit
                               && !s_q.time_step_bit && ({1'b0, tk_frac} + 32'(s_q.incr)
                               > {1'b0, ptpsta_pkg::DEC_MAX})
                               |=> tk_sec == $past(tk_sec) + 32'h1 && tk_frac < 31'(s_q.incr))
    else $error("decimal rollover wrong");
  bin_wrap_a: assert property (!s_q.decimal_rollover_select && !s_q.time_load_bit
                               && !s_q.time_step_bit && ({1'b0, tk_frac} + 32'(s_q.incr)
                               > {1'b0, ptpsta_pkg::BIN_MAX})
                               |=> tk_sec == $past(tk_sec) + 32'h1)
    else $error("binary rollover wrong");

endmodule : ptpsta_top

// ==== dv/ptpsta_top_bench.sv ====
//------------------------------------------------------------
// Self-checking bench of the system time access block
//------------------------------------------------------------
module ptpsta_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // Expected read word, the bits that matter in it and the response.
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0] resp;
  } ptpsta_note_type;

  logic core_clk;
  logic rst;
  logic [11:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  int n_fail = 0;
  int samples_checked = 0;
  integer seed;
  logic [1:0] bq[$];
  ptpsta_note_type rq[$];
  logic [31:0] s, a, a2, mode;
  logic [30:0] mx;
  logic [11:0] regs[6] = '{12'h700, 12'h704, 12'h708, 12'h70c, 12'h710, 12'h714};

  // Block under test.
  ptpsta_top dut_u (
    .core_clk(core_clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  //------------------------------------------------------------
  // Reporting
  //------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // Compares a response code.
  task automatic check_resp(input logic [1:0] e, input logic [1:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected resp at %0t: exp %h got %h", $time, e, g);
    end
  endtask : check_resp

  // Compares the masked part of a read word.
  task automatic check_data(input ptpsta_note_type n, input logic [31:0] g);
    samples_checked++;
    if ((g & n.mask) !== (n.data & n.mask))
    begin
      n_fail++;
      $display("unexpected data at %0t: exp %h got %h", $time, n.data, g);
    end
  endtask : check_data

  // A wait that ran out counts as a mismatch and ends the run.
  task automatic timeout();
    n_fail++;
    $display("unexpected hang at %0t: exp %h got %h", $time, 1'b1, 1'b0);
    wrap_up();
  endtask : timeout

  //------------------------------------------------------------
  // Bus master
  //------------------------------------------------------------
  // Offers address and data together and holds bready until the answer.
  task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [3:0] st = 4'hf,
                    input logic [1:0] r = ptpsta_pkg::RESP_OKAY);
    int k;
    bq.push_back(r);
    @(posedge core_clk);
    s_axi_awaddr <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
        break;
    end
    s_axi_bready <= 1'b0;
    if (k == 100)
      timeout();
  endtask : wr

  // Offers a read address and holds rready until the data come.
  task automatic rd(input logic [11:0] ad, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff,
                    input logic [1:0] r = ptpsta_pkg::RESP_OKAY);
    int k;
    rq.push_back('{e, m, r});
    @(posedge core_clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    s_axi_rready <= 1'b0;
    if (k == 100)
      timeout();
  endtask : rd

  //------------------------------------------------------------
  // Clock, monitor and sequence
  //------------------------------------------------------------
  // Free-running 100 MHz clock.
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Each answer is matched against the oldest note of its kind.
  always @(posedge core_clk)
  begin
    if (!rst && s_axi_bvalid === 1'b1 && s_axi_bready)
      check_resp((bq.size() > 0) ? bq.pop_front() : 2'bxx, s_axi_bresp);
    if (!rst && s_axi_rvalid === 1'b1 && s_axi_rready)
    begin
      ptpsta_note_type n;
      n = (rq.size() > 0) ? rq.pop_front() : 'x;
      check_data(n, s_axi_rdata);
      check_resp(n.resp, s_axi_rresp);
    end
  end

  // Main sequence.
  initial
  begin
    seed = 32'h31c5353c;
    rst = 1'b1;
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    foreach (regs[i])
      rd(regs[i], 32'h0);
    $display("reset test done");
    for (int m = 0; m < 2; m++)
    begin
      mode = (m == 1) ? 32'h0000_0200 : 32'h0;
      mx = (m == 1) ? ptpsta_pkg::DEC_MAX : ptpsta_pkg::BIN_MAX;
      s = $random(seed);
      a = $random(seed);
      a2 = $random(seed);
      // Both adjustment halves go in before the load and the first two steps.
      wr(ptpsta_pkg::OFF_ADJ_SEC, s);
      wr(ptpsta_pkg::OFF_ADJ_SUB, {1'b0, mx - 31'd3});
      wr(ptpsta_pkg::OFF_CTRL, mode | 32'h4);
      rd(ptpsta_pkg::OFF_SEC, s);
      rd(ptpsta_pkg::OFF_SUB, {1'b0, mx - 31'd3});
      rd(ptpsta_pkg::OFF_CTRL, mode);
      wr(ptpsta_pkg::OFF_ADJ_SEC, a);
      wr(ptpsta_pkg::OFF_ADJ_SUB, 32'h5);
      wr(ptpsta_pkg::OFF_CTRL, mode | 32'h8);
      rd(ptpsta_pkg::OFF_SEC, s + a + 32'h1);
      rd(ptpsta_pkg::OFF_SUB, 32'h1);
      rd(ptpsta_pkg::OFF_CTRL, mode);
      wr(ptpsta_pkg::OFF_ADJ_SEC, a2);
      wr(ptpsta_pkg::OFF_ADJ_SUB, 32'h8000_0002);
      wr(ptpsta_pkg::OFF_CTRL, mode | 32'h8);
      rd(ptpsta_pkg::OFF_SEC, s + a - a2);
      rd(ptpsta_pkg::OFF_SUB, {1'b0, mx});
      // Subtracting step without a borrow, seconds offset still a2.
      wr(ptpsta_pkg::OFF_ADJ_SUB, 32'h8000_0003);
      wr(ptpsta_pkg::OFF_CTRL, mode | 32'h8);
      rd(ptpsta_pkg::OFF_SEC, s + a - a2 - a2);
      rd(ptpsta_pkg::OFF_SUB, {1'b0, mx - 31'd3});
      wr(ptpsta_pkg::OFF_INCR, 32'h10);
      wr(ptpsta_pkg::OFF_INCR, 32'h0);
      rd(ptpsta_pkg::OFF_SEC, s + a - a2 - a2 + 32'h1);
      rd(ptpsta_pkg::OFF_SUB, 32'h0, 32'hffff_fc00);
      $display("load step rollover test mode %0d done", m);
    end
    wr(ptpsta_pkg::OFF_SEC, 32'hffff_ffff);
    rd(ptpsta_pkg::OFF_SEC, s + a - a2 - a2 + 32'h1);
    wr(12'h7f0, $random(seed), 4'hf, ptpsta_pkg::RESP_SLVERR);
    rd(12'h7f0, 32'h0, 32'hffff_ffff, ptpsta_pkg::RESP_SLVERR);
    wr(ptpsta_pkg::OFF_ADJ_SEC, 32'hffff_ffff, 4'h1);
    rd(ptpsta_pkg::OFF_ADJ_SEC, {a2[31:8], 8'hff});
    $display("access test done");
    // A second reset in mid-run must bring time and control back to zero.
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(ptpsta_pkg::OFF_SEC, 32'h0);
    rd(ptpsta_pkg::OFF_SUB, 32'h0);
    rd(ptpsta_pkg::OFF_CTRL, 32'h0);
    $display("mid-run reset test done");
    repeat (3) @(posedge core_clk);
    wrap_up();
  end

endmodule : ptpsta_top_bench
